// *** mfa_pkg.sv ***
package mfa_pkg;

  // ------------------------------------------------------------
  // Register offsets
  // ------------------------------------------------------------
  localparam logic [7:0] MFA_ADR_VLIM_FIRST = 8'h2b;
  localparam logic [7:0] MFA_ADR_VLIM_LAST  = 8'h32;
  localparam logic [7:0] MFA_ADR_THOT       = 8'h39;
  localparam logic [7:0] MFA_ADR_THYST      = 8'h3a;
  localparam logic [7:0] MFA_ADR_CFG        = 8'h40;
  localparam logic [7:0] MFA_ADR_FLAGS      = 8'h41;
  localparam logic [7:0] MFA_ADR_MASK       = 8'h43;
  localparam logic [7:0] MFA_ADR_TMODE      = 8'h4b;

  // ------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------
  // Nominal input reads as code 0xc0; limits are 1.1x and 0.9x
  localparam logic [7:0] MFA_VHI_RST   = 8'hd3;
  localparam logic [7:0] MFA_VLO_RST   = 8'had;
  localparam logic [7:0] MFA_THOT_RST  = 8'h50;
  localparam logic [7:0] MFA_THYST_RST = 8'h41;
  localparam logic [7:0] MFA_CFG_RST   = 8'h08;
  localparam logic [7:0] MFA_FLAGS_RST = 8'h00;
  localparam logic [4:0] MFA_MASK_RST  = 5'h00;
  localparam logic [1:0] MFA_TMODE_RST = 2'h0;

  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int MFA_CFG_RUN_BIT   = 0;
  localparam int MFA_CFG_AEN_BIT   = 1;
  localparam int MFA_CFG_ACLR_BIT  = 3;
  localparam int MFA_CFG_RESET_BIT = 7;
  localparam int MFA_TEMP_BIT      = 4;
  localparam int MFA_NCH           = 4;

  // ------------------------------------------------------------
  // Modes and states
  // ------------------------------------------------------------
  localparam logic [1:0] MFA_TM_ONETIME = 2'h1;
  localparam logic [1:0] MFA_TM_COMPAR  = 2'h2;

  typedef enum logic [3:0] {
    MFA_OT_ARMED = 4'h1,
    MFA_OT_HOT   = 4'h2,
    MFA_OT_COOL  = 4'h4,
    MFA_OT_CLEAR = 4'h8
  } mfa_ot_e;

  // ------------------------------------------------------------
  // Carriers
  // ------------------------------------------------------------
  typedef struct packed {
    logic            done;
    logic [3:0][7:0] volt;
    logic [7:0]      temp;
  } mfa_conv_s;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } mfa_reg_req_s;

  typedef struct packed {
    logic [7:0]      cfg;
    logic [4:0]      mask;
    logic [1:0]      tmode;
    logic [3:0][7:0] vhi;
    logic [3:0][7:0] vlo;
    logic [7:0]      thot;
    logic [7:0]      thyst;
    logic [4:0]      flags;
    logic            def_hot;
    logic            tfault;
    mfa_ot_e         ot;
    logic [7:0]      rdata;
    logic            alert_oe;
    logic            alert_o;
    logic            run;
  } mfa_state_s;

endpackage

// *** mfa_fault_alert.sv ***
// Functional notes
// - Flag bits 0-3 mark voltage channels, bit 4 temperature, 1 means crossed
// - Status at 41h, reads only, clears to 00h, bits 5-7 reserved
// - Voltage below low or above high limit flags and alerts; limits 2Bh-32h
// - Voltage limits start at 1.1x and 0.9x nominal
// - Hot limit starts at +80, hysteresis limit at +65 degrees
// - Default and one-time modes: status read clears status and alert
// - Mask at 43h, reset 00h; a set bit hides flag and alert
// - Mode register 4Bh bits 1:0: default, one-time, comparator, default
// - Comparator mode: alert clears only when temperature fault is gone
// - Comparator read during temperature fault keeps bit 4; afterwards clears all
// - Fault still present after clearing read re-alerts at next conversion
// - Alert blocked while alert-enable config bit 1 is zero
// - Alerts never stop conversions; results keep updating
// - Alert line is open drain, driven only low
// - Default mode: hot alert repeats each conversion until below hysteresis
// - One-time mode: after cleared hot alert, next alert at below hysteresis
// - Comparator mode: alert held while above hot; reads then keep bit 4
// - Alert-clear config bit 3 releases alert, status untouched
`timescale 1ns/1ps
`default_nettype none

module mfa_fault_alert
  import mfa_pkg::*;
(
  // Clock and reset
  input  wire logic         mclk,
  input  wire logic         sys_rst,
  // Conversion results from the measurement loop
  input  wire mfa_conv_s    conv,
  // Register access from the serial engine
  input  wire mfa_reg_req_s req,
  output logic [7:0]        rd_data,
  // Measurement loop run request
  output logic              meas_run,
  // Open-drain alert pin, active low
  output logic              alert_o,
  output logic              alert_oe
);

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  mfa_state_s s_q;
  mfa_state_s s_d;

  logic       st_rd;
  logic [3:0] vfault;
  logic       t_hot;
  logic       t_cool;
  logic [4:0] set_ev;
  logic [2:0] lim_idx;
  logic       alert_src;

  assign st_rd   = req.rd && (req.addr == MFA_ADR_FLAGS);
  assign t_hot   = $signed(conv.temp) > $signed(s_q.thot);
  assign t_cool  = $signed(conv.temp) < $signed(s_q.thyst);
  assign lim_idx = 3'(req.addr - MFA_ADR_VLIM_FIRST);

  for (genvar i = 0; i < MFA_NCH; i++) begin : g_cmp
    assign vfault[i] = (conv.volt[i] < s_q.vlo[i]) ||
                       (conv.volt[i] > s_q.vhi[i]);
  end

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb begin
    s_d       = s_q;
    set_ev    = 5'h00;
    alert_src = 1'b0;

    // Register writes
    if (req.wr) begin
      if (req.addr >= MFA_ADR_VLIM_FIRST && req.addr <= MFA_ADR_VLIM_LAST)
      begin
        if (lim_idx[0]) begin
          s_d.vlo[lim_idx[2:1]] = req.wdata;
        end else begin
          s_d.vhi[lim_idx[2:1]] = req.wdata;
        end
      end
      case (req.addr)
        MFA_ADR_THOT:  s_d.thot  = req.wdata;
        MFA_ADR_THYST: s_d.thyst = req.wdata;
        MFA_ADR_CFG:   s_d.cfg   = req.wdata;
        MFA_ADR_MASK:  s_d.mask  = req.wdata[4:0];
        MFA_ADR_TMODE: s_d.tmode = req.wdata[1:0];
        default: ;
      endcase
    end

    // Register reads, value before any clearing effect
    if (req.rd) begin
      if (req.addr >= MFA_ADR_VLIM_FIRST && req.addr <= MFA_ADR_VLIM_LAST)
      begin
        s_d.rdata = lim_idx[0] ? s_q.vlo[lim_idx[2:1]]
                               : s_q.vhi[lim_idx[2:1]];
      end else begin
        case (req.addr)
          MFA_ADR_THOT:  s_d.rdata = s_q.thot;
          MFA_ADR_THYST: s_d.rdata = s_q.thyst;
          MFA_ADR_CFG:   s_d.rdata = s_q.cfg;
          MFA_ADR_FLAGS: s_d.rdata = {3'h0, s_q.flags & ~s_q.mask};
          MFA_ADR_MASK:  s_d.rdata = {3'h0, s_q.mask};
          MFA_ADR_TMODE: s_d.rdata = {6'h00, s_q.tmode};
          default:       s_d.rdata = 8'h00;
        endcase
      end
    end

    // Clearing read; comparator keeps bit 4 while fault stands
    if (st_rd) begin
      if (s_q.tmode == MFA_TM_COMPAR && s_q.tfault) begin
        s_d.flags = s_q.flags & 5'h10;
      end else begin
        s_d.flags = 5'h00;
      end
      case (s_q.ot)
        MFA_OT_HOT:   s_d.ot = MFA_OT_COOL;
        MFA_OT_CLEAR: s_d.ot = MFA_OT_ARMED;
        default: ;
      endcase
    end

    // Conversion results; a set in the clearing cycle still wins
    if (conv.done) begin
      set_ev[3:0] = vfault;
      s_d.tfault  = t_hot;
      case (s_q.tmode)
        MFA_TM_COMPAR: begin
          set_ev[MFA_TEMP_BIT] = t_hot;
        end
        MFA_TM_ONETIME: begin
          case (s_d.ot)
            MFA_OT_ARMED: begin
              if (t_hot) begin
                set_ev[MFA_TEMP_BIT] = 1'b1;
                s_d.ot = MFA_OT_HOT;
              end
            end
            MFA_OT_COOL: begin
              if (t_cool) begin
                set_ev[MFA_TEMP_BIT] = 1'b1;
                s_d.ot = MFA_OT_CLEAR;
              end
            end
            default: ;
          endcase
        end
        default: begin
          // Latched band between hot and hysteresis
          s_d.def_hot = t_hot || (s_q.def_hot && !t_cool);
          set_ev[MFA_TEMP_BIT] = s_d.def_hot;
        end
      endcase
      s_d.flags = s_d.flags | (set_ev & ~s_q.mask);
    end

    // Config reset bit restores every register, itself too
    if (s_q.cfg[MFA_CFG_RESET_BIT]) begin
      s_d.cfg     = MFA_CFG_RST;
      s_d.mask    = MFA_MASK_RST;
      s_d.tmode   = MFA_TMODE_RST;
      s_d.vhi     = {MFA_NCH{MFA_VHI_RST}};
      s_d.vlo     = {MFA_NCH{MFA_VLO_RST}};
      s_d.thot    = MFA_THOT_RST;
      s_d.thyst   = MFA_THYST_RST;
      s_d.flags   = MFA_FLAGS_RST[4:0];
      s_d.def_hot = 1'b0;
      s_d.ot      = MFA_OT_ARMED;
    end

    // Alert source: comparator temp follows the live fault
    if (s_d.tmode == MFA_TM_COMPAR) begin
      alert_src = s_d.tfault && !s_d.mask[MFA_TEMP_BIT];
    end else begin
      alert_src = s_d.flags[MFA_TEMP_BIT] &&
                  !s_d.mask[MFA_TEMP_BIT];
    end
    alert_src = alert_src ||
                (|(s_d.flags[3:0] & ~s_d.mask[3:0]));
    s_d.alert_oe = alert_src && s_d.cfg[MFA_CFG_AEN_BIT] &&
                   !s_d.cfg[MFA_CFG_ACLR_BIT];
    s_d.alert_o  = 1'b0;
    // Loop keeps running whatever the alert does
    s_d.run = s_d.cfg[MFA_CFG_RUN_BIT] &&
              !s_d.cfg[MFA_CFG_ACLR_BIT];
  end

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      s_q.cfg      <= MFA_CFG_RST;
      s_q.mask     <= MFA_MASK_RST;
      s_q.tmode    <= MFA_TMODE_RST;
      s_q.vhi      <= {MFA_NCH{MFA_VHI_RST}};
      s_q.vlo      <= {MFA_NCH{MFA_VLO_RST}};
      s_q.thot     <= MFA_THOT_RST;
      s_q.thyst    <= MFA_THYST_RST;
      s_q.flags    <= MFA_FLAGS_RST[4:0];
      s_q.def_hot  <= 1'b0;
      s_q.tfault   <= 1'b0;
      s_q.ot       <= MFA_OT_ARMED;
      s_q.rdata    <= 8'h00;
      s_q.alert_oe <= 1'b0;
      s_q.alert_o  <= 1'b0;
      s_q.run      <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  assign rd_data  = s_q.rdata;
  assign meas_run = s_q.run;
  assign alert_o  = s_q.alert_o;
  assign alert_oe = s_q.alert_oe;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  AST_FLAG_MAP: assert property (
    conv.done && !s_q.cfg[7] && vfault[0] && !s_q.mask[0]
    |=> s_q.flags[0])
    else $error("Voltage fault did not set its flag");
  AST_RESERVED: assert property (
    req.rd && req.addr == MFA_ADR_FLAGS |=> rd_data[7:5] == 3'h0)
    else $error("Reserved status bits read nonzero");
  AST_READ_CLR: assert property (
    st_rd && !conv.done && s_q.tmode != MFA_TM_COMPAR
    |=> s_q.flags == 5'h00)
    else $error("Status read did not clear flags");
  AST_MASK_HIDES: assert property (
    s_q.mask[0] && !$past(req.wr) && $past(s_q.mask[0])
    && !$past(s_q.flags[0]) |-> !s_q.flags[0])
    else $error("Masked channel set its flag");
  AST_COMP_ALERT: assert property (
    s_q.tmode == MFA_TM_COMPAR && conv.done && t_hot && !s_q.cfg[7]
    && !req.wr && s_q.cfg[1] && !s_q.cfg[3] && !s_q.mask[4]
    |=> alert_oe)
    else $error("Comparator alert missing while hot");
  AST_KEEP_BIT4: assert property (
    st_rd && s_q.tmode == MFA_TM_COMPAR && s_q.tfault && s_q.flags[4]
    && !conv.done && !s_q.cfg[7] |=> s_q.flags[4])
    else $error("Bit 4 lost while fault stands");
  AST_AEN_BLOCK: assert property (
    !s_q.cfg[MFA_CFG_AEN_BIT] |=> !alert_oe || $past(req.wr))
    else $error("Alert driven while disabled");
  AST_ACLR: assert property (
    s_q.cfg[MFA_CFG_ACLR_BIT] && !req.wr |=> !alert_oe)
    else $error("Alert held while clear bit set");
  AST_DRIVE_LOW: assert property (
    alert_oe |-> !alert_o)
    else $error("Alert line driven high");
  AST_ONETIME: assert property (
    s_q.ot == MFA_OT_COOL && s_q.tmode == MFA_TM_ONETIME && conv.done
    && t_cool && !s_q.cfg[7] && !req.wr |=> s_q.ot == MFA_OT_CLEAR)
    else $error("One-time cool event missed");

  // ------------------------------------------------------------
  // Mode and limit checks
  // ------------------------------------------------------------
  // Write strobes are left out where a config or mask write moves the result
  AST_NO_FALSE_FLAG: assert property (
    !s_q.flags[2] && !(conv.done && vfault[2])
    |=> !s_q.flags[2])
    else $error("Voltage flag set without a fault");
  AST_STATUS_RO: assert property (
    req.wr && req.addr == MFA_ADR_FLAGS && !st_rd && !conv.done
    && !s_q.cfg[MFA_CFG_RESET_BIT] |=> $stable(s_q.flags))
    else $error("Write changed the status register");
  AST_VOLT_LOW: assert property (
    conv.done && conv.volt[0] < s_q.vlo[0] && !s_q.mask[0]
    && !s_q.cfg[7] |=> s_q.flags[0])
    else $error("Low voltage did not set its flag");
  AST_VOLT_HIGH: assert property (
    conv.done && conv.volt[3] > s_q.vhi[3] && !s_q.mask[3]
    && !s_q.cfg[7] |=> s_q.flags[3])
    else $error("High voltage did not set its flag");
  AST_REALERT: assert property (
    conv.done && vfault[2] && !s_q.mask[2] && !req.wr
    && !s_q.cfg[7] && s_q.cfg[1] && !s_q.cfg[3]
    |=> alert_oe)
    else $error("Standing voltage fault did not alert again");
  AST_DEF_REPEAT: assert property (
    s_q.tmode != MFA_TM_ONETIME && s_q.tmode != MFA_TM_COMPAR
    && conv.done && s_q.def_hot && !t_cool && !s_q.mask[4]
    && !s_q.cfg[7] |=> s_q.flags[4])
    else $error("Default mode did not repeat hot flag");
  AST_DEF_COOL: assert property (
    s_q.tmode != MFA_TM_ONETIME && s_q.tmode != MFA_TM_COMPAR
    && conv.done && t_cool && !t_hot |=> !s_q.def_hot)
    else $error("Default mode stayed hot below hysteresis");
  AST_MODE3_DEF: assert property (
    s_q.tmode == 2'h3 && conv.done && t_hot && !s_q.mask[4]
    && !s_q.cfg[7] |=> s_q.flags[4])
    else $error("Mode code 3 did not act as default");
  AST_ONETIME_QUIET: assert property (
    s_q.tmode == MFA_TM_ONETIME && s_q.ot == MFA_OT_COOL && conv.done
    && !t_cool && !s_q.flags[4] && !s_q.cfg[7] |=> !s_q.flags[4])
    else $error("One-time mode flagged before cooling");
  AST_REARM: assert property (
    s_q.ot == MFA_OT_CLEAR && st_rd && !conv.done && !s_q.cfg[7]
    |=> s_q.ot == MFA_OT_ARMED)
    else $error("One-time mode did not rearm");
  AST_COMP_HOLD: assert property (
    s_q.tmode == MFA_TM_COMPAR && s_q.tfault && st_rd && !conv.done
    && !req.wr && !s_q.cfg[7] && s_q.cfg[1] && !s_q.cfg[3]
    && !s_q.mask[4] |=> alert_oe)
    else $error("Status read released comparator alert");
  AST_COMP_DROP: assert property (
    s_q.tmode == MFA_TM_COMPAR && conv.done && !t_hot && !req.wr
    && !s_q.cfg[7] && vfault == 4'h0 && s_q.flags[3:0] == 4'h0
    |=> !alert_oe)
    else $error("Comparator alert held after fault gone");
  AST_RUN_ON_ALERT: assert property (
    alert_oe && s_q.cfg[MFA_CFG_RUN_BIT] && !s_q.cfg[MFA_CFG_ACLR_BIT]
    |-> meas_run)
    else $error("Alert stopped the measurement loop");

  COV_DEFAULT_HOT: cover property (
    s_q.tmode == 2'h0 && s_q.flags[4] ##1 st_rd);
  COV_ONETIME_LOOP: cover property (
    s_q.ot == MFA_OT_CLEAR ##[1:50] s_q.ot == MFA_OT_ARMED);
  COV_COMP_RELEASE: cover property (
    s_q.tmode == MFA_TM_COMPAR && alert_oe ##1 !alert_oe);
  // Voltage alert answered by a read; alert held off by the clear bit
  COV_VOLT_ALERT: cover property (
    alert_oe && s_q.flags[3:0] != 4'h0 ##1 st_rd);
  COV_ACLR_HOLD: cover property (
    s_q.cfg[MFA_CFG_ACLR_BIT] && s_q.flags != 5'h00);

endmodule

`default_nettype wire

// *** mfa_alert_pullup.sv ***
`timescale 1ns/1ps
`default_nettype none

module mfa_alert_pullup (
  // Open-drain driver of the monitored device
  input  wire logic alert_o,
  input  wire logic alert_oe,
  // Shared interrupt line seen by the host
  output logic      alert_line
);
  // Released line goes to the pull-up level, never the last value
  assign alert_line = alert_oe ? alert_o : 1'b1;
endmodule

`default_nettype wire

// *** monitor_fault_alert_logic_test.sv ***
`timescale 1ns/1ps
`default_nettype none

module monitor_fault_alert_logic_test;
  import mfa_pkg::*;
  localparam logic [7:0] N    = 8'hc0;
  localparam logic [7:0] T25  = 8'h19;
  localparam logic [7:0] HOT  = 8'h51;
  localparam logic [7:0] MID  = 8'h46;
  localparam logic [7:0] COOL = 8'h40;
  logic            mclk;
  logic            sys_rst;
  mfa_conv_s       conv;
  mfa_reg_req_s    req;
  logic [7:0]      rd_data;
  logic            meas_run;
  logic            alert_o;
  logic            alert_oe;
  logic            alert_line;
  logic [3:0][7:0] v;
  int              error_cnt;
  int              compares;

  mfa_fault_alert dut (
    .mclk(mclk), .sys_rst(sys_rst), .conv(conv), .req(req),
    .rd_data(rd_data), .meas_run(meas_run), .alert_o(alert_o),
    .alert_oe(alert_oe));
  mfa_alert_pullup host (
    .alert_o(alert_o), .alert_oe(alert_oe), .alert_line(alert_line));

  always #5 mclk = ~mclk;

  // ----------------------------------------
  // Access tasks
  // ----------------------------------------
  task automatic chk(input string nm, input logic [7:0] e,
                     input logic [7:0] a);
    compares++;
    if (a !== e) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, e, a);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge mclk);
    req.wr <= 1'b0;
    @(posedge mclk);
  endtask

  // Read data holds, so sampling one edge late is safe
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge mclk);
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge mclk);
    req.rd <= 1'b0;
    @(posedge mclk);
    #1;
    chk("rd_data", e, rd_data);
  endtask

  task automatic cv(input logic [7:0] v0, v1, v2, v3, t);
    @(posedge mclk);
    conv <= '{done: 1'b1, volt: {v3, v2, v1, v0}, temp: t};
    @(posedge mclk);
    conv.done <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic cvt(input logic [7:0] t);
    cv(N, N, N, N, t);
  endtask

  task automatic al(input logic e);
    #1;
    chk("alert_line", {7'h00, ~e}, {7'h00, alert_line});
    if (e) begin
      chk("alert_o", 8'h00, {7'h00, alert_o});
      chk("meas_run", 8'h01, {7'h00, meas_run});
    end
  endtask

  task automatic end_sim;
    $display("Compares %0d errors %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    repeat (20000) @(posedge mclk);
    error_cnt++;
    end_sim();
  end

  initial begin
    mclk = 1'b0;
    sys_rst = 1'b1;
    conv = '0;
    req = '0;
    error_cnt = 0;
    compares = 0;
    repeat (5) @(posedge mclk);
    sys_rst <= 1'b0;
    rd(MFA_ADR_FLAGS, 8'h00);
    rd(MFA_ADR_MASK, 8'h00);
    rd(MFA_ADR_TMODE, 8'h00);
    rd(MFA_ADR_VLIM_FIRST, 8'hd3);
    rd(MFA_ADR_VLIM_LAST, 8'had);
    rd(MFA_ADR_THOT, 8'h50);
    rd(MFA_ADR_THYST, 8'h41);
    rd(8'h60, 8'h00);
    wr(MFA_ADR_CFG, 8'h03);
    wr(MFA_ADR_FLAGS, 8'hff);
    rd(MFA_ADR_FLAGS, 8'h00);
    // Values on the limits themselves are in range
    cv(8'had, 8'hd3, N, N, T25);
    al(1'b0);
    for (int ch = 0; ch < 4; ch++) begin
      v = {4{N}};
      v[ch] = ch[0] ? 8'hd4 : 8'hac;
      repeat (2) begin
        cv(v[0], v[1], v[2], v[3], T25);
        al(1'b1);
        rd(MFA_ADR_FLAGS, 8'h01 << ch);
        al(1'b0);
      end
      rd(MFA_ADR_FLAGS, 8'h00);
    end
    wr(MFA_ADR_MASK, 8'h01);
    rd(MFA_ADR_MASK, 8'h01);
    cv(8'hac, N, N, N, T25);
    al(1'b0);
    rd(MFA_ADR_FLAGS, 8'h00);
    wr(MFA_ADR_MASK, 8'h00);
    wr(MFA_ADR_CFG, 8'h01);
    cv(N, 8'hd4, N, N, T25);
    al(1'b0);
    rd(MFA_ADR_FLAGS, 8'h02);
    wr(MFA_ADR_CFG, 8'h03);
    cv(N, N, 8'hac, N, T25);
    wr(MFA_ADR_CFG, 8'h0b);
    al(1'b0);
    chk("meas_run", 8'h00, {7'h00, meas_run});
    wr(MFA_ADR_CFG, 8'h03);
    rd(MFA_ADR_FLAGS, 8'h04);
    // Codes 00 and 11 both behave as default
    for (int m = 0; m < 4; m += 3) begin
      wr(MFA_ADR_TMODE, 8'(m));
      cvt(HOT);
      al(1'b1);
      rd(MFA_ADR_FLAGS, 8'h10);
      al(1'b0);
      cvt(MID);
      al(1'b1);
      rd(MFA_ADR_FLAGS, 8'h10);
      cvt(COOL);
      al(1'b0);
      rd(MFA_ADR_FLAGS, 8'h00);
    end
    wr(MFA_ADR_TMODE, 8'h01);
    cvt(HOT);
    al(1'b1);
    rd(MFA_ADR_FLAGS, 8'h10);
    cvt(HOT);
    al(1'b0);
    cvt(COOL);
    al(1'b1);
    rd(MFA_ADR_FLAGS, 8'h10);
    cvt(COOL);
    al(1'b0);
    cvt(HOT);
    al(1'b1);
    rd(MFA_ADR_FLAGS, 8'h10);
    wr(MFA_ADR_TMODE, 8'h02);
    cv(8'hac, N, N, N, HOT);
    al(1'b1);
    rd(MFA_ADR_FLAGS, 8'h11);
    al(1'b1);
    rd(MFA_ADR_FLAGS, 8'h10);
    cvt(MID);
    al(1'b0);
    rd(MFA_ADR_FLAGS, 8'h10);
    rd(MFA_ADR_FLAGS, 8'h00);
    // Raised low limit flags a nominal input; config bit 7 restores all
    wr(MFA_ADR_VLIM_FIRST + 8'h01, 8'hc1);
    rd(MFA_ADR_VLIM_FIRST + 8'h01, 8'hc1);
    cvt(T25);
    al(1'b1);
    rd(MFA_ADR_FLAGS, 8'h01);
    wr(MFA_ADR_THOT, 8'h20);
    rd(MFA_ADR_THOT, 8'h20);
    wr(MFA_ADR_CFG, 8'h80);
    rd(MFA_ADR_VLIM_FIRST + 8'h01, 8'had);
    rd(MFA_ADR_THOT, 8'h50);
    rd(MFA_ADR_TMODE, 8'h00);
    rd(MFA_ADR_CFG, 8'h08);
    al(1'b0);
    end_sim();
  end
endmodule

`default_nettype wire
